// >>> logic/docs_stage.v
// one directional overcurrent stage: blocking, timing, events, records
`timescale 1ns/1ps
`include "docs_map.vh"

// Overview of operation
// R1: block input sampled on each processing tick before pick-up and timing.
// R2: external block arrives on its own port, apart from inrush blocking.
// R3: pick-up without block asserts start and runs operate timing.
// R4: block present at pick-up gives blocked instead, no timing or trip.
// R5: block after start clears operate timing and runs release handling.
// R6: block must arrive 5 ms before operate delay ends to stop trip.
// R7: inrush blocking enable bit, default off, suppresses only own trip.
// R8: inrush blocks when harmonic ratio exceeds limit in 0.01 percent steps.
// R9: operating angle published, current minus voltage angle, 0.01 degree.
// R10: expected operate time at 5 ms; inverse mode follows highest current.
// R11: remaining time to trip, signed, 5 ms steps, up to 1800 s.
// R12: highest current over pick-up setting published in hundredths.
// R13: definite and inverse with minimum delay for operate; release is definite only.
// R14: per-event mask chooses which ON and OFF events reach the buffer.
// R15: each event shows the timestamp of the latest masked status change.
// R16: start, trip and blocked counters, each clearable on request.
// R17: four instances, each tags its events with its own identifier.
// R18: twelve event codes: start, trip, block, no-volt, live angle, voltmem.
// R19: twelve-entry circular fault record store, oldest overwritten.
// R20: record written only on ON of start, trip or blocked.
// R21: record holds time, event, type, currents, avg, remaining, group, angle.
// R22: pick-up drops only below 97 percent of the setting.
// R23: voltage under 1 V uses stored angle 0.5 s, then reference zero.
// R24: block released clears blocked and, if picked up, gives start in that same tick.
module docs_stage #(
  parameter       STAGE_ID = 0,
  parameter       TICK_CYC = `DOCS_CLK_KHZ * `DOCS_TICK_MS
) (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire        blockIn,
  input  wire [15:0] maxCurrent,
  input  wire [2:0]  faultType,
  input  wire [15:0] preAvgCurrent,
  input  wire [15:0] harmRatio,
  input  wire [15:0] curAngle,
  input  wire [15:0] voltAngle,
  input  wire        voltLow,
  input  wire [2:0]  settingGroup,
  input  wire [31:0] timeStamp,
  output wire        startOut,
  output wire        tripOut,
  output wire        blockedOut,
  output wire        evValid,
  input  wire        evReady,
  output reg  [3:0]  evCode,
  output wire [1:0]  evStage,
  output reg  [31:0] evTime
);
  localparam [6:0] S_IDLE = 7'h01, S_START = 7'h02, S_TRIP = 7'h04;
  localparam [6:0] S_BLK = 7'h08, S_REL = 7'h10;
  localparam integer PRE_TICKS = `DOCS_PRE_MS / `DOCS_TICK_MS;
  localparam integer VMEM_TICKS = `DOCS_VMEM_MS / `DOCS_TICK_MS;

  reg  [31:0] tickCnt_r;
  reg         tick_r;
  reg  [6:0]  state_r;
  reg  [1:0]  cfg_r;
  reg  [15:0] iset_r, harmLim_r;
  reg  [19:0] opDly_r, opMin_r, relDly_r;
  reg  [11:0] evMask_r, evPend_r;
  reg  [19:0] opCnt_r, relCnt_r;
  reg         pickUp_r, blkSmp_r, ack_r;
  reg  [15:0] cntSt_r, cntTr_r, cntBl_r;
  reg  [15:0] hist_r [0:PRE_TICKS-1];
  reg  [7:0]  vmemCnt_r;
  reg         vLowPrev_r;
  reg  [15:0] angMem_r;
  reg  [3:0]  recWr_r, recSel_r;
  reg  [31:0] recTime_r [0:`DOCS_RECS-1];
  reg  [8:0]  recInfo_r [0:`DOCS_RECS-1];
  reg  [31:0] recCur_r  [0:`DOCS_RECS-1];
  reg  [31:0] recAvg_r  [0:`DOCS_RECS-1];
  reg  [19:0] recRem_r  [0:`DOCS_RECS-1];
  reg  [6:0]  stateNxt;
  reg  [19:0] target;
  reg  [11:0] evSet, evPendNxt;
  integer     k, j;

  wire        acc = (read | write) & ~ack_r;
  // a write lands only at the edge where waitrequest is seen low
  wire        wrTake = write & ack_r;
  wire [2:0]  cntClr = {3{wrTake && address == `DOCS_A_CMD}} & writedata[2:0];
  wire [31:0] ratioFull = ({16'h0000, maxCurrent} * 32'd100) /
                          {16'h0000, (iset_r == 16'h0000) ? 16'h0001 : iset_r};
  wire [15:0] ratio = ratioFull[15:0];
  wire        pickHi = maxCurrent > iset_r;
  wire        pickLo = ({16'h0000, maxCurrent} * 32'd100) <
                       ({16'h0000, iset_r} * {25'h0, `DOCS_DROP_PCT});
  wire        inrushBlk = cfg_r[`DOCS_CFG_INRUSH] &
                          (harmRatio > harmLim_r);                  // R7 R8
  wire        useMem = voltLow & (vmemCnt_r != 8'h00);
  wire [15:0] refAng = voltLow ? (useMem ? angMem_r : 16'h0000) : voltAngle;
  wire [15:0] opAngle = curAngle - refAng;                          // R9 R23
  wire [19:0] invTime = (ratio > 16'd100) ?
                        opDly_r * 20'd100 / {4'h0, ratio - 16'd100} : opDly_r;
  wire [19:0] remTime = target - opCnt_r;                           // R11

  // operate delay target: inverse tracks current, floored at minimum
  always @* begin
    if (!cfg_r[`DOCS_CFG_INV])
      target = opDly_r;                                             // R13
    else if (invTime < opMin_r)
      target = opMin_r;                                             // R13
    else
      target = invTime;                                             // R10
  end

  assign waitrequest = (read | write) & ~ack_r;
  assign startOut = (state_r == S_START) | (state_r == S_TRIP);
  assign tripOut = (state_r == S_TRIP);
  assign blockedOut = (state_r == S_BLK);
  assign evValid = |evPend_r;
  assign evStage = STAGE_ID[1:0];                                   // R17

  // processing tick divider; one stage pass per tick
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tickCnt_r == TICK_CYC - 1);
      tickCnt_r <= (tickCnt_r == TICK_CYC - 1) ? 32'h0 : tickCnt_r + 32'h1;
    end
  end

  // stage sequencer, evaluated on the tick only
  always @* begin
    stateNxt = state_r;
    case (state_r)
      S_IDLE, S_REL: begin
        if (pickUp_r && blkSmp_r)
          stateNxt = S_BLK;                                         // R4
        else if (pickUp_r)
          stateNxt = S_START;                                       // R3
        else if (state_r == S_REL && relCnt_r >= relDly_r)
          stateNxt = S_IDLE;
      end
      S_START: begin
        if (blkSmp_r || !pickUp_r)
          stateNxt = S_REL;                                         // R5
        else if (opCnt_r + 20'h1 >= target && !inrushBlk)
          stateNxt = S_TRIP;                                        // R7
      end
      S_TRIP: begin
        if (blkSmp_r || !pickUp_r)
          stateNxt = S_REL;
      end
      S_BLK: begin
        if (!blkSmp_r)
          stateNxt = pickUp_r ? S_START : S_IDLE;                   // R24
      end
      default: stateNxt = S_IDLE;
    endcase
  end

  // events of this tick: ON on even code, OFF on odd code
  always @* begin
    evSet = 12'h000;
    if (tick_r) begin
      evSet[0] = ~startOut & (stateNxt == S_START);
      evSet[1] = startOut & ~(stateNxt == S_START | stateNxt == S_TRIP);
      evSet[2] = ~tripOut & (stateNxt == S_TRIP);
      evSet[3] = tripOut & (stateNxt != S_TRIP);
      evSet[4] = ~blockedOut & (stateNxt == S_BLK);
      evSet[5] = blockedOut & (stateNxt != S_BLK);
      // no-voltage block starts when memory runs out or was never filled
      evSet[6] = voltLow & ((vmemCnt_r == 8'h01) |
                            (~vLowPrev_r & (vmemCnt_r == 8'h00)));
      evSet[7] = ~voltLow & vLowPrev_r & (vmemCnt_r == 8'h00);
      evSet[8] = ~voltLow & vLowPrev_r;
      evSet[9] = voltLow & ~vLowPrev_r;
      evSet[10] = voltLow & ~vLowPrev_r & (vmemCnt_r != 8'h00);
      evSet[11] = voltLow ? (vmemCnt_r == 8'h01) :
                            (vLowPrev_r & (vmemCnt_r != 8'h00));
    end
  end

  // pending set after this cycle's take and this tick's new events
  always @* begin
    evPendNxt = (evPend_r & ~((evValid && evReady) ? (12'h001 << evCode) :
                 12'h000)) | (evSet & evMask_r);                    // R14
  end

  // stage state, timers, angle memory and sampling
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
      opCnt_r <= 20'h0;
      relCnt_r <= 20'h0;
      pickUp_r <= 1'b0;
      blkSmp_r <= 1'b0;
      vmemCnt_r <= 8'h00;
      vLowPrev_r <= 1'b0;
      angMem_r <= 16'h0;
      for (k = 0; k < PRE_TICKS; k = k + 1)
        hist_r[k] <= 16'h0;
    end else if (tick_r) begin
      blkSmp_r <= blockIn;                                          // R1 R2
      if (pickHi)
        pickUp_r <= 1'b1;
      else if (pickLo)
        pickUp_r <= 1'b0;                                           // R22
      state_r <= stateNxt;
      // block after start wipes operate time at once
      if (stateNxt == S_START)
        opCnt_r <= (state_r == S_START) ? opCnt_r + 20'h1 : opCnt_r;
      else if (stateNxt == S_REL && blkSmp_r)
        opCnt_r <= 20'h0;                                           // R5
      else if (stateNxt == S_IDLE || stateNxt == S_BLK)
        opCnt_r <= 20'h0;
      relCnt_r <= (stateNxt == S_REL) ? relCnt_r + 20'h1 : 20'h0;   // R13
      vLowPrev_r <= voltLow;
      if (!voltLow) begin
        angMem_r <= voltAngle;
        vmemCnt_r <= VMEM_TICKS[7:0];                               // R23
      end else if (vmemCnt_r != 8'h00)
        vmemCnt_r <= vmemCnt_r - 8'h01;
      hist_r[0] <= maxCurrent;
      for (k = 1; k < PRE_TICKS; k = k + 1)
        hist_r[k] <= hist_r[k-1];
    end
  end

  // event queue: one code per handshake, set beats take
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evPend_r <= 12'h000;
      evCode <= 4'h0;
      evTime <= 32'h0;
    end else begin
      evPend_r <= evPendNxt;
      if (|(evSet & evMask_r))
        evTime <= timeStamp;                                        // R15
      // shown code stands until taken; next lowest comes from the new set
      if (!(evValid && !evReady)) begin
        evCode <= 4'h0;
        for (j = `DOCS_RECS - 1; j >= 0; j = j - 1)
          if (evPendNxt[j])
            evCode <= j[3:0];                                       // R18
      end
    end
  end

  // fault records on start, trip or blocked ON only
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      recWr_r <= 4'h0;
    end else if (evSet[0] | evSet[2] | evSet[4]) begin              // R20
      recTime_r[recWr_r] <= timeStamp;                              // R21
      recInfo_r[recWr_r] <= {evSet[4] ? 3'h4 : (evSet[2] ? 3'h2 : 3'h0),
                             faultType, settingGroup};
      recCur_r[recWr_r] <= {hist_r[PRE_TICKS-1], maxCurrent};
      recAvg_r[recWr_r] <= {preAvgCurrent, opAngle};
      recRem_r[recWr_r] <= remTime;
      recWr_r <= (recWr_r == `DOCS_RECS - 1) ? 4'h0 : recWr_r + 4'h1; // R19
    end
  end

  // bus slave writes and counters; a count in the clear cycle restarts from one
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      cfg_r <= 2'b00;                                               // R7
      iset_r <= `DOCS_RST_ISET;
      harmLim_r <= `DOCS_RST_HLIM;                                  // R8
      opDly_r <= 20'h0;
      opMin_r <= 20'h0;
      relDly_r <= 20'h0;
      evMask_r <= `DOCS_RST_EVMASK;
      recSel_r <= 4'h0;
      cntSt_r <= 16'h0;
      cntTr_r <= 16'h0;
      cntBl_r <= 16'h0;
    end else begin
      ack_r <= acc;
      if (wrTake) begin
        case (address)
          `DOCS_A_CFG:     cfg_r <= writedata[1:0];
          `DOCS_A_ISET:    iset_r <= writedata[15:0];
          `DOCS_A_OPDLY:   opDly_r <= writedata[19:0];
          `DOCS_A_OPMIN:   opMin_r <= writedata[19:0];
          `DOCS_A_RELDLY:  relDly_r <= writedata[19:0];
          `DOCS_A_HARMLIM: harmLim_r <= writedata[15:0];
          `DOCS_A_EVMASK:  evMask_r <= writedata[11:0];
          `DOCS_A_RECSEL:  recSel_r <= writedata[3:0];
          default: ;
        endcase
      end
      // counters count ON events of start, trip, blocked
      if (evSet[0])
        cntSt_r <= (cntClr[0] ? 16'h0 : cntSt_r) + 16'h1;           // R16
      else if (cntClr[0])
        cntSt_r <= 16'h0;
      if (evSet[2])
        cntTr_r <= (cntClr[1] ? 16'h0 : cntTr_r) + 16'h1;
      else if (cntClr[1])
        cntTr_r <= 16'h0;
      if (evSet[4])
        cntBl_r <= (cntClr[2] ? 16'h0 : cntBl_r) + 16'h1;
      else if (cntClr[2])
        cntBl_r <= 16'h0;
    end
  end

  // read data registered at the accepting edge; unmapped reads zero
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= 32'h0;
    end else if (acc && read) begin
      case (address)
        `DOCS_A_CFG:     readdata <= {30'h0, cfg_r};
        `DOCS_A_ISET:    readdata <= {16'h0, iset_r};
        `DOCS_A_OPDLY:   readdata <= {12'h0, opDly_r};
        `DOCS_A_OPMIN:   readdata <= {12'h0, opMin_r};
        `DOCS_A_RELDLY:  readdata <= {12'h0, relDly_r};
        `DOCS_A_HARMLIM: readdata <= {16'h0, harmLim_r};
        `DOCS_A_EVMASK:  readdata <= {20'h0, evMask_r};
        `DOCS_A_STATUS:  readdata <= {25'h0, useMem, voltLow, inrushBlk,
                                      blockedOut, tripOut, startOut};
        `DOCS_A_ANGLE:   readdata <= {{16{opAngle[15]}}, opAngle};  // R9
        `DOCS_A_EXPTIME: readdata <= {12'h0, target};               // R10
        `DOCS_A_REMTIME: readdata <= {{12{remTime[19]}}, remTime};  // R11
        `DOCS_A_RATIO:   readdata <= {16'h0, ratio};                // R12
        `DOCS_A_CNTST:   readdata <= {16'h0, cntSt_r};
        `DOCS_A_CNTTR:   readdata <= {16'h0, cntTr_r};
        `DOCS_A_CNTBL:   readdata <= {16'h0, cntBl_r};
        `DOCS_A_RECSEL:  readdata <= {24'h0, recWr_r, recSel_r};
        `DOCS_A_RECTIME: readdata <= recTime_r[recSel_r];
        `DOCS_A_RECINFO: readdata <= {23'h0, recInfo_r[recSel_r]};
        `DOCS_A_RECCUR:  readdata <= recCur_r[recSel_r];
        `DOCS_A_RECAVG:  readdata <= recAvg_r[recSel_r];
        `DOCS_A_RECREM:  readdata <= {12'h0, recRem_r[recSel_r]};
        default:         readdata <= 32'h0;
      endcase
    end
  end
endmodule // docs_stage

// >>> logic/docs_map.vh
// register offsets, field positions and timing figures of the stage
`ifndef DOCS_MAP_VH
`define DOCS_MAP_VH
`define DOCS_A_CFG      8'h00
`define DOCS_A_ISET     8'h04
`define DOCS_A_OPDLY    8'h08
`define DOCS_A_OPMIN    8'h0c
`define DOCS_A_RELDLY   8'h10
`define DOCS_A_HARMLIM  8'h14
`define DOCS_A_EVMASK   8'h18
`define DOCS_A_CMD      8'h1c
`define DOCS_A_STATUS   8'h20
`define DOCS_A_ANGLE    8'h24
`define DOCS_A_EXPTIME  8'h28
`define DOCS_A_REMTIME  8'h2c
`define DOCS_A_RATIO    8'h30
`define DOCS_A_CNTST    8'h34
`define DOCS_A_CNTTR    8'h38
`define DOCS_A_CNTBL    8'h3c
`define DOCS_A_RECSEL   8'h40
`define DOCS_A_RECTIME  8'h44
`define DOCS_A_RECINFO  8'h48
`define DOCS_A_RECCUR   8'h4c
`define DOCS_A_RECAVG   8'h50
`define DOCS_A_RECREM   8'h54
`define DOCS_CFG_INV    0
`define DOCS_CFG_INRUSH 1
`define DOCS_RST_ISET   16'h0078
`define DOCS_RST_HLIM   16'h0001
`define DOCS_RST_EVMASK 12'hfff
`define DOCS_DROP_PCT   7'h61
`define DOCS_TICK_MS    5
`define DOCS_CLK_KHZ    50000
`define DOCS_VMEM_MS    500
`define DOCS_PRE_MS     20
`define DOCS_RECS       12
// event codes: start, trip, block, no-voltage, live angle, voltmem
`define DOCS_EV_STON    4'h0
`define DOCS_EV_TRON    4'h2
`define DOCS_EV_BLON    4'h4
`define DOCS_EV_NVON    4'h6
`define DOCS_EV_LAON    4'h8
`define DOCS_EV_VMON    4'ha
`endif

// >>> verification/docs_ev_sink.sv
// event buffer model that takes the stage's events, promptly or stalling
`timescale 1ns/1ps
module docs_ev_sink (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        slow,
  input  wire        evValid,
  input  wire [3:0]  evCode,
  input  wire [31:0] evTime,
  output reg         evReady
);
  int          codeQ[$];
  logic [31:0] timeQ[$];

  // one event per accepting edge; slow mode stalls at random
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evReady <= 1'b0;
    end else begin
      if (evValid && evReady) begin
        codeQ.push_back(evCode);
        timeQ.push_back(evTime);
      end
      evReady <= slow ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule // docs_ev_sink

// >>> verification/docs_chk.sv
// port checker of the overcurrent stage, bound into the design
`timescale 1ns/1ps
module docs_chk #(
  parameter STAGE_ID = 0,
  parameter TICK_CYC = 20
) (
  input wire       mclk,
  input wire       arst_n,
  input wire       read,
  input wire       write,
  input wire       waitrequest,
  input wire       blockIn,
  input wire       startOut,
  input wire       tripOut,
  input wire       blockedOut,
  input wire       evValid,
  input wire       evReady,
  input wire [3:0] evCode,
  input wire [1:0] evStage
);
  // decisions use the previous tick's sample, so they lag up to two ticks
  localparam int BLKWIN = 2 * TICK_CYC + 2;
  logic [31:0] sinceHi, sinceLo;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // cycles since block input was last high, and since it was last low
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sinceHi <= 32'hffffffff;
      sinceLo <= 32'h0;
    end else begin
      sinceHi <= blockIn ? 32'h0 : sinceHi + 32'(sinceHi != 32'hffffffff);
      sinceLo <= blockIn ? sinceLo + 32'(sinceLo != 32'hffffffff) : 32'h0;
    end
  end
  sequence s_req; $rose(read || write); endsequence
  sequence s_ans; waitrequest ##1 !waitrequest; endsequence

  a_bus_answer: assert property (s_req |-> s_ans)
    else $error("bus answer not one cycle after request");
  a_bus_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high without a request");
  a_start_block: assert property (!(startOut && blockedOut))
    else $error("start and blocked together");
  a_trip_blocked: assert property (blockedOut |-> !tripOut)
    else $error("trip while blocked");
  a_trip_after: assert property ($rose(tripOut) |-> $past(startOut))
    else $error("trip without prior start");
  a_blk_cause: assert property ($rose(blockedOut) |-> sinceHi <= BLKWIN)
    else $error("blocked without block input");
  a_start_cause: assert property ($rose(startOut) |-> sinceLo <= BLKWIN)
    else $error("start while block input high");
  a_blk_release: assert property (blockedOut |-> sinceHi <= BLKWIN)
    else $error("blocked kept after block release");
  a_ev_hold: assert property (evValid && !evReady |=> evValid)
    else $error("event dropped before taken");
  a_ev_code: assert property (evValid && !evReady |=> $stable(evCode))
    else $error("event code changed before taken");
  a_stage_tag: assert property (evStage == 2'(STAGE_ID))
    else $error("wrong stage identifier");
endmodule // docs_chk

bind docs_stage docs_chk #(.STAGE_ID(STAGE_ID), .TICK_CYC(TICK_CYC)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .read(read), .write(write),
  .waitrequest(waitrequest), .blockIn(blockIn), .startOut(startOut),
  .tripOut(tripOut), .blockedOut(blockedOut), .evValid(evValid),
  .evReady(evReady), .evCode(evCode), .evStage(evStage));

// >>> verification/docs_stage_tb.sv
// self-checking bench of one overcurrent stage with an event sink
`timescale 1ns/1ps
`include "docs_map.vh"
module docs_stage_tb;
  localparam int TK = 20;
  logic mclk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic blockIn = 1'b0, voltLow = 1'b0, slow = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0, timeStamp = 32'h0, ts1, q;
  logic [15:0] maxCurrent = 16'h0, harmRatio = 16'h0, preAvgCurrent = 16'h0;
  logic [15:0] curAngle = 16'h0, voltAngle = 16'h0, ang;
  logic [2:0]  faultType = 3'h0, settingGroup = 3'h0;
  wire  [31:0] readdata, evTime;
  wire  [3:0]  evCode;
  wire  [1:0]  evStage;
  wire         waitrequest, startOut, tripOut, blockedOut, evValid, evReady;
  wire  [2:0]  st = {blockedOut, tripOut, startOut};
  int num_errors = 0, n_compared = 0, seedv, k;
  int expQ[$];
  int cnt[3] = '{0, 0, 0};

  docs_stage #(.STAGE_ID(2), .TICK_CYC(TK)) u_docs_stage (
    .mclk(mclk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .blockIn(blockIn), .maxCurrent(maxCurrent),
    .faultType(faultType), .preAvgCurrent(preAvgCurrent),
    .harmRatio(harmRatio), .curAngle(curAngle), .voltAngle(voltAngle),
    .voltLow(voltLow), .settingGroup(settingGroup), .timeStamp(timeStamp),
    .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut),
    .evValid(evValid), .evReady(evReady), .evCode(evCode),
    .evStage(evStage), .evTime(evTime));
  docs_ev_sink u_sink (.mclk(mclk), .arst_n(arst_n), .slow(slow),
    .evValid(evValid), .evCode(evCode), .evTime(evTime), .evReady(evReady));

  always #10 mclk = ~mclk;

  task automatic final_report();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic waitst(input int b, input logic v);
    for (int i = 0; i < 12 * TK && st[b] !== v; i++) @(posedge mclk);
    chk(st[b], v);
  endtask
  // new current with fresh random context and timestamp
  task automatic apply(input logic [15:0] cur);
    @(posedge mclk);
    maxCurrent <= cur;
    faultType <= 3'($urandom);
    settingGroup <= 3'($urandom);
    preAvgCurrent <= 16'($urandom);
    curAngle <= 16'($urandom);
    voltAngle <= 16'($urandom);
    ts1 = $urandom;
    timeStamp <= ts1;
  endtask
  // model of the event buffer and counters
  task automatic ex(input int c);
    expQ.push_back(c);
    if (c % 2 == 0 && c < 6) cnt[c / 2]++;
  endtask
  task automatic evcmp();
    int g[$];
    repeat (TK) @(posedge mclk);
    g = u_sink.codeQ;
    g.sort();
    expQ.sort();
    chk(g.size(), expQ.size());
    foreach (expQ[i]) if (i < g.size()) chk(g[i], expQ[i]);
    expQ.delete();
    u_sink.codeQ.delete();
    u_sink.timeQ.delete();
  endtask

  // watchdog: whole run is a few thousand cycles
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    final_report();
  end

  initial begin
    seedv = $urandom(47522);
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    rdchk(`DOCS_A_CFG, 32'h0);
    rdchk(`DOCS_A_ISET, 32'h78);
    rdchk(`DOCS_A_HARMLIM, 32'h1);
    rdchk(`DOCS_A_EVMASK, 32'hfff);
    rdchk(8'hfc, 32'h0);
    bus(1'b1, `DOCS_A_OPDLY, 32'h3);
    bus(1'b1, `DOCS_A_RELDLY, 32'h0);
    repeat (3 * TK) @(posedge mclk);
    u_sink.codeQ.delete();
    u_sink.timeQ.delete();
    // definite delay: start, trip, hysteresis, dropout
    apply(16'd240);
    waitst(0, 1'b1);
    waitst(1, 1'b1);
    ex(0); ex(2);
    chk(u_sink.timeQ[0], ts1);
    rdchk(`DOCS_A_RATIO, 32'd200);
    rdchk(`DOCS_A_EXPTIME, 32'd3);
    bus(1'b1, `DOCS_A_RECSEL, 32'h0);
    rdchk(`DOCS_A_RECTIME, ts1);
    rdchk(`DOCS_A_RECCUR, 32'h000000f0);
    apply(16'd117);
    repeat (2 * TK) @(posedge mclk);
    chk(startOut, 1'b1);
    apply(16'd116);
    waitst(0, 1'b0);
    waitst(1, 1'b0);
    ex(1); ex(3);
    evcmp();
    // block present at pick-up, then released; sink stalls now
    slow <= 1'b1;
    blockIn <= 1'b1;
    apply(16'd240);
    waitst(2, 1'b1);
    repeat (3 * TK) @(posedge mclk);
    chk(st[1:0], 2'b00);
    blockIn <= 1'b0;
    waitst(2, 1'b0);
    waitst(0, 1'b1);
    apply(16'd0);
    waitst(0, 1'b0);
    ex(4); ex(5); ex(0); ex(1);
    evcmp();
    // inrush blocking holds back only the trip
    bus(1'b1, `DOCS_A_CFG, 32'h2);
    bus(1'b1, `DOCS_A_HARMLIM, 32'd1500);
    harmRatio <= 16'd2000;
    apply(16'd240);
    waitst(0, 1'b1);
    repeat (6 * TK) @(posedge mclk);
    chk(tripOut, 1'b0);
    harmRatio <= 16'd1000;
    waitst(1, 1'b1);
    apply(16'd0);
    waitst(0, 1'b0);
    waitst(1, 1'b0);
    ex(0); ex(2); ex(1); ex(3);
    evcmp();
    // inverse delay tracks the current, falling to equal the minimum
    bus(1'b1, `DOCS_A_CFG, 32'h1);
    bus(1'b1, `DOCS_A_OPDLY, 32'h4);
    bus(1'b1, `DOCS_A_OPMIN, 32'h2);
    apply(16'd240);
    waitst(0, 1'b1);
    rdchk(`DOCS_A_EXPTIME, 32'd4);
    apply(16'd300);
    repeat (TK + 4) @(posedge mclk);
    rdchk(`DOCS_A_EXPTIME, 32'd2);
    waitst(1, 1'b1);
    apply(16'd0);
    waitst(0, 1'b0);
    waitst(1, 1'b0);
    ex(0); ex(2); ex(1); ex(3);
    evcmp();
    // counters, then clear on request
    for (k = 0; k < 3; k++) rdchk(`DOCS_A_CNTST + 8'(4 * k), cnt[k]);
    bus(1'b1, `DOCS_A_CMD, 32'h7);
    for (k = 0; k < 3; k++) rdchk(`DOCS_A_CNTST + 8'(4 * k), 32'h0);
    // block arriving after start, well before the delay ends
    bus(1'b1, `DOCS_A_CFG, 32'h0);
    apply(16'd240);
    waitst(0, 1'b1);
    blockIn <= 1'b1;
    repeat (6 * TK) @(posedge mclk);
    chk(tripOut, 1'b0);
    apply(16'd0);
    repeat (2 * TK) @(posedge mclk);
    blockIn <= 1'b0;
    waitst(2, 1'b0);
    ex(0); ex(1); ex(4); ex(5);
    // voltage loss: memory angle for a while, then zero reference
    ang = curAngle - voltAngle;
    voltLow <= 1'b1;
    voltAngle <= 16'($urandom);
    repeat (2 * TK) @(posedge mclk);
    rdchk(`DOCS_A_ANGLE, {{16{ang[15]}}, ang});
    rdchk(`DOCS_A_STATUS, 32'h30);
    repeat (100 * TK) @(posedge mclk);
    rdchk(`DOCS_A_ANGLE, {{16{curAngle[15]}}, curAngle});
    rdchk(`DOCS_A_STATUS, 32'h10);
    voltLow <= 1'b0;
    repeat (2 * TK) @(posedge mclk);
    ex(9); ex(10); ex(11); ex(6); ex(7); ex(8);
    evcmp();
    final_report();
  end
endmodule // docs_stage_tb
